// ==== rtl/iap_pkg.sv ====
/*
 * constants for the in-application flash sequencer: register offsets,
 * mode codes, unlock bytes, field positions, reset values and timing.
 * assumes a 32-bit apb slave with one register per aligned word.
 */
package iap_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0c;
    localparam logic [7:0] OFS_UNLOCK = 8'h10;
    localparam logic [7:0] OFS_CONTROL = 8'h14;
    localparam logic [7:0] OFS_LOW_BOUNDARY = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    // mode codes of the mode-select register
    localparam logic [3:0] MODE_STANDBY = 4'h0;
    localparam logic [3:0] MODE_READ = 4'h1;
    localparam logic [3:0] MODE_PROGRAM = 4'h2;
    localparam logic [3:0] MODE_ERASE = 4'h3;
    localparam logic [3:0] MODE_LB_WRITE = 4'h4;
    localparam logic [3:0] MODE_LB_READ = 4'h5;
    // unlock bytes
    localparam logic [7:0] UNLOCK_FIRST = 8'h46;
    localparam logic [7:0] UNLOCK_SECOND = 8'hb9;
    // control register fields
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_FAIL_BIT = 4;
    // reset values
    localparam logic [7:0] RST_DATA = 8'hff;
    localparam logic [7:0] RST_ADDR = 8'h00;
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [7:0] RST_LOW_BOUNDARY = 8'hff;
    // memory layout
    localparam int AP_SIZE_BYTES = 4096;
    localparam logic [15:0] BOOT_START = 16'h1800;
    localparam int PAGE_BYTES = 512;
    localparam int FLASH_BYTES = 8192;
    // busy time of one flash operation
    localparam int OP_TIME_NS = 200;
    localparam int CLK_PERIOD_NS = 20;
    localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
    // sequencer states
    typedef enum logic [1:0] {
        IAP_IDLE = 2'b00,
        IAP_ARMED = 2'b01,
        IAP_BUSY = 2'b10
    } iap_state_t;
endpackage : iap_pkg

// ==== rtl/iap_flash_array.sv ====
/*
 * flash array model: byte read, byte program (and with stored value)
 * and page erase to all ones. assumes the sequencer gives one strobe
 * per operation and holds the address while it is busy.
 */
`timescale 1ns/1ps
`default_nettype none
module iap_flash_array #(
    parameter int BYTES = iap_pkg::FLASH_BYTES,
    parameter int PAGE = iap_pkg::PAGE_BYTES
) (
    input wire logic pclk,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic prog_stb,
    input wire logic erase_stb,
    output logic [7:0] rdata
);
    logic [7:0] mem [BYTES];
    logic [$clog2(BYTES)-1:0] idx;
    logic [$clog2(BYTES)-1:0] page_base;

    // no reset: flash contents survive a system reset
    assign idx = addr[$clog2(BYTES)-1:0];
    assign page_base = idx & ~($clog2(BYTES)'(PAGE - 1));
    assign rdata = mem[idx];

    // programming can only clear bits, erase sets a whole page
    always_ff @(posedge pclk) begin
        if (prog_stb) begin
            mem[idx] <= mem[idx] & wdata;
        end
        for (int i = 0; i < PAGE; i++) begin
            if (erase_stb) begin
                mem[page_base + $clog2(BYTES)'(i)] <= 8'hff;
            end
        end
    end
endmodule : iap_flash_array
`default_nettype wire

// ==== rtl/iap_data_flash_seq.sv ====
/*
 * in-application flash sequencer with apb register access.
 * assumes a single apb master, and a boot-source level input that is
 * stable from reset (sampled through two flops anyway).
 * the flash array sub-block keeps its contents across reset, and
 * software polls nothing: the bus itself stalls while busy.
 */
// Functional notes
// - the application region is the low 4k bytes of flash.
// - data flash spans from low boundary times 256 up to the boot start.
// - after an application boot, operations reach only the data flash.
// - after an application boot, erase and program of application or boot region are blocked.
// - after a boot-loader boot, application and data flash are both open.
// - all boot-loader modes are offered through the same registers.
// - mode 03h with a page address erases that page.
// - mode 02h programs the data register byte at the address.
// - mode 01h places the flash byte in the data register.
// - an operation starts on 46h then b9h to the unlock port with enable set.
// - the cpu is stalled while an operation runs, interrupts held off.
// - with the enable bit clear, no operation runs.
// - the fail flag is set on a refused operation and cleared on success.
`timescale 1ns/1ps
`default_nettype none
module iap_data_flash_seq #(
    parameter int OP_CYCLES = iap_pkg::OP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic boot_from_loader,
    output logic cpu_wait,
    output logic irq_block
);
    // software-visible registers and sequencer state
    iap_pkg::iap_state_t state, next_state;
    logic [3:0] flash_mode_select, next_flash_mode_select;
    logic [7:0] flash_address_high, next_flash_address_high;
    logic [7:0] flash_address_low, next_flash_address_low;
    logic [7:0] flash_data_port, next_flash_data_port;
    logic [7:0] data_flash_low_boundary, next_data_flash_low_boundary;
    logic flash_op_enable, next_flash_op_enable;
    logic command_fail_flag, next_command_fail_flag;
    logic [15:0] timer, next_timer;

    // decode, region and strobe wires
    logic boot_meta, boot_sync;
    logic wr, rd, mapped;
    logic [15:0] addr, lb_addr;
    logic in_data, in_app, allowed, mode_ok;
    logic prog_stb, erase_stb;
    logic [7:0] flash_rdata;

    // apb qualifiers; reads latch in the setup cycle
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~pwrite;
    assign addr = {flash_address_high, flash_address_low};
    assign lb_addr = {data_flash_low_boundary, 8'h00};
    // address decode; unmapped words error
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= iap_pkg::OFS_STATUS);

    // boot source crosses in from a strap pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_meta <= 1'b0;
            boot_sync <= 1'b0;
        end else begin
            boot_meta <= boot_from_loader;
            boot_sync <= boot_meta;
        end
    end

    // region checks
    always_comb begin
        in_data = (addr >= lb_addr) && (addr < iap_pkg::BOOT_START);
        in_app = addr < 16'(iap_pkg::AP_SIZE_BYTES);
        mode_ok = flash_mode_select inside {iap_pkg::MODE_READ, iap_pkg::MODE_PROGRAM, iap_pkg::MODE_ERASE,
            iap_pkg::MODE_LB_WRITE, iap_pkg::MODE_LB_READ};
        // boundary modes never touch the array, so no region check
        if (flash_mode_select == iap_pkg::MODE_LB_WRITE || flash_mode_select == iap_pkg::MODE_LB_READ) begin
            allowed = mode_ok;
        end else if (boot_sync) begin
            allowed = mode_ok && (in_app || in_data);
        end else begin
            allowed = mode_ok && in_data;
        end
    end

    // accesses stall for the whole busy time, reads included
    assign pready = (state != iap_pkg::IAP_BUSY);
    assign pslverr = psel & penable & pready & ~mapped;
    assign cpu_wait = (state == iap_pkg::IAP_BUSY);
    assign irq_block = (state == iap_pkg::IAP_BUSY);

    // register and sequencer next state
    always_comb begin
        next_state = state;
        next_flash_mode_select = flash_mode_select;
        next_flash_address_high = flash_address_high;
        next_flash_address_low = flash_address_low;
        next_flash_data_port = flash_data_port;
        next_data_flash_low_boundary = data_flash_low_boundary;
        next_flash_op_enable = flash_op_enable;
        next_command_fail_flag = command_fail_flag;
        next_timer = timer;
        // strobes last one cycle, at the end of the busy time
        prog_stb = 1'b0;
        erase_stb = 1'b0;
        // writes land only in an access phase outside the busy state
        if (wr && pready && state != iap_pkg::IAP_BUSY) begin
            unique case (paddr)
                iap_pkg::OFS_MODE: next_flash_mode_select = pwdata[3:0];
                iap_pkg::OFS_ADDR_HIGH: next_flash_address_high = pwdata[7:0];
                iap_pkg::OFS_ADDR_LOW: next_flash_address_low = pwdata[7:0];
                iap_pkg::OFS_DATA: next_flash_data_port = pwdata[7:0];
                // fail bit is read-only, only enable is stored
                iap_pkg::OFS_CONTROL: next_flash_op_enable = pwdata[iap_pkg::CTRL_ENABLE_BIT];
                iap_pkg::OFS_UNLOCK: begin
                    if (state == iap_pkg::IAP_IDLE) begin
                        next_state = (pwdata[7:0] == iap_pkg::UNLOCK_FIRST) ? iap_pkg::IAP_ARMED
                                                                           : iap_pkg::IAP_IDLE;
                    end else if (pwdata[7:0] == iap_pkg::UNLOCK_SECOND && flash_op_enable) begin
                        if (allowed) begin
                            next_state = iap_pkg::IAP_BUSY;
                            next_timer = 16'(OP_CYCLES - 1);
                        end else begin
                            next_state = iap_pkg::IAP_IDLE;
                            next_command_fail_flag = 1'b1;
                        end
                    end else begin
                        // a 46h here re-arms, anything else restarts
                        next_state = (pwdata[7:0] == iap_pkg::UNLOCK_FIRST) ? iap_pkg::IAP_ARMED
                                                                           : iap_pkg::IAP_IDLE;
                    end
                end
                // boundary and status words are read-only here
                default: ;
            endcase
        end else if (state == iap_pkg::IAP_BUSY) begin
            if (timer != 16'h0000) begin
                // count down the busy time
                next_timer = timer - 16'h0001;
            end else begin
                // commit at the end of the busy time
                next_state = iap_pkg::IAP_IDLE;
                next_command_fail_flag = 1'b0;
                unique case (flash_mode_select)
                    iap_pkg::MODE_READ: next_flash_data_port = flash_rdata;
                    iap_pkg::MODE_PROGRAM: prog_stb = 1'b1;
                    iap_pkg::MODE_ERASE: erase_stb = 1'b1;
                    iap_pkg::MODE_LB_WRITE: next_data_flash_low_boundary = flash_data_port;
                    iap_pkg::MODE_LB_READ: next_flash_data_port = data_flash_low_boundary;
                    default: ;
                endcase
            end
        end
    end

    // registers only; all decisions live in the comb block above
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= iap_pkg::IAP_IDLE;
            flash_mode_select <= iap_pkg::RST_MODE;
            flash_address_high <= iap_pkg::RST_ADDR;
            flash_address_low <= iap_pkg::RST_ADDR;
            flash_data_port <= iap_pkg::RST_DATA;
            data_flash_low_boundary <= iap_pkg::RST_LOW_BOUNDARY;
            flash_op_enable <= 1'b0;
            command_fail_flag <= 1'b0;
            timer <= 16'h0000;
        end else begin
            state <= next_state;
            flash_mode_select <= next_flash_mode_select;
            flash_address_high <= next_flash_address_high;
            flash_address_low <= next_flash_address_low;
            flash_data_port <= next_flash_data_port;
            data_flash_low_boundary <= next_data_flash_low_boundary;
            flash_op_enable <= next_flash_op_enable;
            command_fail_flag <= next_command_fail_flag;
            timer <= next_timer;
        end
    end

    // read mux, registered off the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd && !penable) begin
            unique case (paddr)
                iap_pkg::OFS_MODE: prdata <= {28'h0, flash_mode_select};
                iap_pkg::OFS_ADDR_HIGH: prdata <= {24'h0, flash_address_high};
                iap_pkg::OFS_ADDR_LOW: prdata <= {24'h0, flash_address_low};
                iap_pkg::OFS_DATA: prdata <= {24'h0, flash_data_port};
                iap_pkg::OFS_CONTROL: prdata <= {24'h0, flash_op_enable, 2'b00, command_fail_flag, 4'h0};
                iap_pkg::OFS_LOW_BOUNDARY: prdata <= {24'h0, data_flash_low_boundary};
                iap_pkg::OFS_STATUS: prdata <= {29'h0, boot_sync, state};
                // unmapped words read as zero
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // live address pair; it holds while busy because writes stall
    iap_flash_array u_array (
        .pclk(pclk),
        .addr(addr),
        .wdata(flash_data_port),
        .prog_stb(prog_stb),
        .erase_stb(erase_stb),
        .rdata(flash_rdata)
    );
endmodule : iap_data_flash_seq
`default_nettype wire

// ==== tb/iap_seq_checker.sv ====
/* port checker for the flash sequencer.
 * assumes a bind from the bench top, one clock, async low reset. */
`timescale 1ns/1ps
`default_nettype none
module iap_seq_checker #(
    parameter int OP_CYCLES = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cpu_wait,
    input wire logic irq_block
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic acc;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // stall length counter, cleared between stalls
    always_comb next_cnt = cpu_wait ? cnt + 8'h01 : 8'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt <= 8'h00;
        else
            cnt <= next_cnt;
    end
    assign acc = psel && penable && pready;
    property p_wait_irq; cpu_wait == irq_block; endproperty
    property p_busy_stall; cpu_wait && psel && penable |-> !pready; endproperty
    property p_idle_ready; !cpu_wait && psel && penable |-> pready; endproperty
    property p_start;
        $rose(cpu_wait) |-> $past(acc && pwrite && paddr == iap_pkg::OFS_UNLOCK
            && pwdata[7:0] == iap_pkg::UNLOCK_SECOND);
    endproperty
    property p_len; $fell(cpu_wait) |-> cnt == OP_CYCLES; endproperty
    property p_max; cpu_wait |-> cnt < OP_CYCLES; endproperty
    property p_rearm; $fell(cpu_wait) |-> !cpu_wait [*3]; endproperty
    // unmapped or unaligned offsets answer with an error, mapped ones never do
    property p_bad_addr;
        psel && penable && pready && (paddr > iap_pkg::OFS_STATUS || paddr[1:0] != 2'b00) |-> pslverr;
    endproperty
    property p_good_addr;
        psel && penable && paddr <= iap_pkg::OFS_STATUS && paddr[1:0] == 2'b00 |-> !pslverr;
    endproperty
    a_wait_irq: assert property (p_wait_irq) else $error("irq block differs from wait");
    a_busy_stall: assert property (p_busy_stall) else $error("bus answered while busy");
    a_idle_ready: assert property (p_idle_ready) else $error("bus stalled while idle");
    a_start: assert property (p_start) else $error("stall without second unlock byte");
    a_len: assert property (p_len) else $error("stall length wrong");
    a_max: assert property (p_max) else $error("stall too long");
    a_rearm: assert property (p_rearm) else $error("restart without unlock");
    a_bad_addr: assert property (p_bad_addr) else $error("no error on bad offset");
    a_good_addr: assert property (p_good_addr) else $error("error on mapped offset");
    c_stall: cover property ($rose(cpu_wait));
    c_err: cover property (acc && pslverr);
    c_wait_bus: cover property (cpu_wait && psel && penable);
endmodule : iap_seq_checker
`default_nettype wire

// ==== tb/tb_iap_data_flash_seq.sv ====
/* bench for the flash sequencer: apb tasks, expected flash image, checks.
 * assumes the package, design and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb_iap_data_flash_seq;
    localparam int OPC = 6;
    logic pclk, presetn, psel, penable, pwrite, boot_from_loader;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, busy;
    logic pready, pslverr, cpu_wait, irq_block, err, en, fl;
    logic [31:0] seed = 32'he7d0bde5;
    logic [7:0] img [0:8191];
    logic [7:0] lb;
    int error_cnt = 0;
    int n_compared = 0;
    iap_data_flash_seq #(.OP_CYCLES(OPC)) iap_data_flash_seq_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .boot_from_loader, .cpu_wait, .irq_block);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction : lfsr
    function automatic logic legal(input logic [3:0] m, input logic [15:0] a);
        if (!en) return 1'b0;
        if (m == iap_pkg::MODE_LB_WRITE || m == iap_pkg::MODE_LB_READ) return 1'b1;
        if (boot_from_loader)
            return a < 16'(iap_pkg::AP_SIZE_BYTES) || (a >= {lb, 8'h00} && a < iap_pkg::BOOT_START);
        return a >= {lb, 8'h00} && a < iap_pkg::BOOT_START;
    endfunction : legal
    task automatic final_report();
        if (error_cnt == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 200);
        if (n >= 200) begin
            error_cnt++;
            $display("[FAIL] %0t bus timeout", $time);
            final_report();
        end
        // answer taken and request released at the same edge
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic watch();
        busy = 32'h00000000;
        repeat (OPC + 6) begin
            @(negedge pclk);
            if (cpu_wait === 1'b1) busy++;
        end
    endtask : watch
    // set up registers, unlock, then compare stall, fail flag and result
    task automatic run(input logic [3:0] m, input logic [15:0] a, input logic [7:0] d);
        logic ok;
        ok = legal(m, a);
        apb(1'b1, iap_pkg::OFS_MODE, {28'h0000000, m});
        apb(1'b1, iap_pkg::OFS_ADDR_HIGH, {24'h000000, a[15:8]});
        apb(1'b1, iap_pkg::OFS_ADDR_LOW, {24'h000000, a[7:0]});
        apb(1'b1, iap_pkg::OFS_DATA, {24'h000000, d});
        apb(1'b1, iap_pkg::OFS_UNLOCK, 32'h00000046);
        apb(1'b1, iap_pkg::OFS_UNLOCK, 32'h000000b9);
        watch();
        chk(busy, ok ? 32'(OPC) : 32'h00000000, "stall cycles");
        if (en) fl = !ok;
        apb(1'b0, iap_pkg::OFS_CONTROL, 32'h00000000);
        chk({31'h00000000, rd[iap_pkg::CTRL_FAIL_BIT]}, {31'h00000000, fl}, "fail flag");
        if (ok && m == iap_pkg::MODE_ERASE)
            for (int i = 0; i < 512; i++) img[{a[15:9], 9'h000} + i] = 8'hff;
        if (ok && m == iap_pkg::MODE_PROGRAM) img[a[12:0]] = img[a[12:0]] & d;
        if (ok && m == iap_pkg::MODE_LB_WRITE) lb = d;
        if (ok && (m == iap_pkg::MODE_READ || m == iap_pkg::MODE_LB_READ)) begin
            apb(1'b0, iap_pkg::OFS_DATA, 32'h00000000);
            chk({24'h000000, rd[7:0]}, {24'h000000, (m == iap_pkg::MODE_READ ? img[a[12:0]] : lb)}, "read byte");
        end
    endtask : run
    task automatic do_reset(input logic boot);
        presetn <= 1'b0;
        boot_from_loader <= boot;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        lb = iap_pkg::RST_LOW_BOUNDARY;
        en = 1'b0;
        fl = 1'b0;
        repeat (3) @(posedge pclk);
    endtask : do_reset
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        do_reset(1'b0);
        apb(1'b0, iap_pkg::OFS_DATA, 32'h00000000);
        chk({24'h000000, rd[7:0]}, {24'h000000, iap_pkg::RST_DATA}, "data reset");
        apb(1'b0, iap_pkg::OFS_LOW_BOUNDARY, 32'h00000000);
        chk({24'h000000, rd[7:0]}, {24'h000000, iap_pkg::RST_LOW_BOUNDARY}, "boundary reset");
        apb(1'b0, 8'h20, 32'h00000000);
        chk({31'h00000000, err}, 32'h00000001, "unmapped offset");
        run(iap_pkg::MODE_LB_WRITE, 16'h0000, 8'h10);
        apb(1'b1, iap_pkg::OFS_CONTROL, 32'h00000080);
        en = 1'b1;
        // a stray byte between the unlock bytes must not start anything
        apb(1'b1, iap_pkg::OFS_UNLOCK, 32'h00000046);
        apb(1'b1, iap_pkg::OFS_UNLOCK, 32'h00000047);
        apb(1'b1, iap_pkg::OFS_UNLOCK, 32'h000000b9);
        watch();
        chk(busy, 32'h00000000, "stray unlock");
        run(iap_pkg::MODE_LB_WRITE, 16'h0000, 8'h10);
        run(iap_pkg::MODE_ERASE, 16'h1000, 8'h00);
        run(iap_pkg::MODE_ERASE, 16'h1400, 8'h00);
        run(iap_pkg::MODE_ERASE, 16'h17ff, 8'h00);
        repeat (8) begin
            seed = lfsr(seed);
            run(iap_pkg::MODE_PROGRAM, {4'h1, 3'h0, seed[8:0]} | {5'h00, seed[31], 10'h000}, seed[23:16]);
            run(iap_pkg::MODE_READ, {4'h1, 3'h0, seed[8:0]} | {5'h00, seed[31], 10'h000}, 8'h00);
        end
        run(iap_pkg::MODE_READ, 16'h17ff, 8'h00);
        run(iap_pkg::MODE_ERASE, 16'h0e00, 8'h00);
        run(iap_pkg::MODE_PROGRAM, 16'h1800, 8'h00);
        run(iap_pkg::MODE_READ, 16'h0fff, 8'h00);
        run(iap_pkg::MODE_READ, 16'h1000, 8'h00);
        run(iap_pkg::MODE_LB_READ, 16'h0000, 8'h00);
        do_reset(1'b1);
        apb(1'b0, iap_pkg::OFS_STATUS, 32'h00000000);
        chk(rd, 32'h00000004, "boot status");
        apb(1'b1, iap_pkg::OFS_CONTROL, 32'h00000080);
        en = 1'b1;
        run(iap_pkg::MODE_ERASE, 16'h0400, 8'h00);
        run(iap_pkg::MODE_PROGRAM, 16'h0455, 8'ha5);
        run(iap_pkg::MODE_READ, 16'h0455, 8'h00);
        final_report();
    end
endmodule : tb_iap_data_flash_seq
bind iap_data_flash_seq iap_seq_checker #(.OP_CYCLES(OP_CYCLES)) iap_seq_checker_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .cpu_wait, .irq_block);
`default_nettype wire
